//--- verilog/compact_instr_field_decoder.sv
// Contract
// - register copy takes two full 5-bit registers
// - stack-pointer word load/store use implicit SP base
// - word load/store offset scaled by four
// - same-register add uses one 5-bit register
// - SP add uses SP as source and destination
// - two-register add maps two 3-bit registers
// - SP-to-register add reads SP, writes 3-bit dst
// - no-op is register copy of r0 to r0
// - negate is subtract from register zero
// - branch offset shifted left one place
// - compact breakpoint and debug breakpoint accepted
// - SP add has nine-bit immediate, one minor bit
// - two-register add has 3-bit imm, minor bit
// - unsigned add has three 3-bit registers
// - SP word load has 5-bit dst, 5-bit offset
// - link jumps differ in delay slot size
// - halfword with major opcode comes first
// - five-bit register fields decode linearly
// - size comes from major opcode alone
module compact_instr_field_decoder (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  input  wire logic                       in_valid,
  input  wire logic [15:0]                in_half,
  output logic                            in_ready,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output dec16_pkg::dec_out_t             out_dec
);

  dec16_pkg::asm_state_t state_reg;
  dec16_pkg::asm_state_t state_next;
  logic [15:0]           first_reg;
  logic [15:0]           first_next;
  logic                  out_valid_reg;
  logic                  valid_next;
  dec16_pkg::dec_out_t   out_reg;
  dec16_pkg::dec_out_t   out_next;
  dec16_pkg::dec_out_t   short_dec;
  dec16_pkg::dec_out_t   wide_dec;
  dec16_pkg::dec_out_t   dec_sel;

  wire dec16_pkg::major_t   major = in_half[dec16_pkg::F_MAJ_LO +: 6];
  wire dec16_pkg::reg_idx_t r5a   = in_half[dec16_pkg::F_R5A_LO +: 5];
  wire dec16_pkg::reg_idx_t r5b   = in_half[dec16_pkg::F_R5B_LO +: 5];
  wire logic [4:0]          minor5 = in_half[4:0];
  wire logic                minor  = in_half[dec16_pkg::F_MINOR];
  wire logic                brk_dbg = in_half[dec16_pkg::F_BRK_SEL];
  dec16_pkg::reg_idx_t      r3a;
  dec16_pkg::reg_idx_t      r3b;
  dec16_pkg::reg_idx_t      r3c;
  logic                     is_short;
  logic                     fire;
  logic                     take_first;
  logic                     done_now;

  size_classifier u_size (
    .major    (major),
    .is_short (is_short)
  );

  reg3_map u_map_a (
    .code    (in_half[dec16_pkg::F_R3A_LO +: 3]),
    .reg_idx (r3a)
  );

  reg3_map u_map_b (
    .code    (in_half[dec16_pkg::F_R3B_LO +: 3]),
    .reg_idx (r3b)
  );

  reg3_map u_map_c (
    .code    (in_half[dec16_pkg::F_R3C_LO +: 3]),
    .reg_idx (r3c)
  );

  assign in_ready   = ce && (!out_valid_reg || out_ready);
  assign fire       = in_valid && in_ready;
  assign take_first = fire && (state_reg == dec16_pkg::ST_FIRST);
  assign done_now   = fire && ((state_reg == dec16_pkg::ST_SECOND) ||
                               is_short);

  // field extraction of the halfword forms
  always_comb begin
    short_dec         = dec16_pkg::DEC_RESET;
    short_dec.op      = dec16_pkg::OP_RESERVED;
    short_dec.raw     = {16'h0000, in_half};
    unique case (major)
      dec16_pkg::MAJ_REG_COPY: begin
        short_dec.dst   = r5a;
        short_dec.src_a = r5b;
        if (r5a == dec16_pkg::ZERO_REG && r5b == dec16_pkg::ZERO_REG) begin
          short_dec.op = dec16_pkg::OP_NO_OP;
        end else begin
          short_dec.op      = dec16_pkg::OP_REG_COPY;
          short_dec.has_dst = 1'b1;
        end
      end
      dec16_pkg::MAJ_GROUP_D: begin
        short_dec.has_dst = 1'b1;
        if (!minor) begin
          short_dec.op    = dec16_pkg::OP_ADD_SAME;
          short_dec.dst   = r5a;
          short_dec.src_a = r5a;
          short_dec.imm   = dec16_pkg::sext(16'(in_half[4:1]), 4);
        end else begin
          short_dec.op    = dec16_pkg::OP_ADD_SP;
          short_dec.dst   = dec16_pkg::SP_REG;
          short_dec.src_a = dec16_pkg::SP_REG;
          short_dec.imm   = dec16_pkg::sext(16'(in_half[9:1]), 9);
        end
      end
      dec16_pkg::MAJ_GROUP_E: begin
        short_dec.has_dst = 1'b1;
        short_dec.dst     = r3a;
        if (!minor) begin
          short_dec.op    = dec16_pkg::OP_ADD_TWO;
          short_dec.src_a = r3b;
          short_dec.imm   = dec16_pkg::sext(16'(in_half[3:1]), 3);
        end else begin
          short_dec.op    = dec16_pkg::OP_ADD_SP_REG;
          short_dec.src_a = dec16_pkg::SP_REG;
          short_dec.imm   = dec16_pkg::zext(16'(in_half[6:1]), 6);
        end
      end
      dec16_pkg::MAJ_GROUP_A: begin
        short_dec.has_dst = 1'b1;
        short_dec.dst     = r3a;
        short_dec.src_a   = r3b;
        short_dec.src_b   = r3c;
        if (!minor) begin
          short_dec.op = dec16_pkg::OP_UADD;
        end else if (r3b == dec16_pkg::ZERO_REG) begin
          short_dec.op = dec16_pkg::OP_NEGATE;
        end else begin
          short_dec.op = dec16_pkg::OP_USUB;
        end
      end
      dec16_pkg::MAJ_WLOAD, dec16_pkg::MAJ_WSTORE: begin
        short_dec.op      = (major == dec16_pkg::MAJ_WLOAD) ?
                            dec16_pkg::OP_WLOAD : dec16_pkg::OP_WSTORE;
        short_dec.has_dst = (major == dec16_pkg::MAJ_WLOAD);
        short_dec.dst     = r3a;
        short_dec.src_b   = r3a;
        short_dec.src_a   = r3b;
        short_dec.imm     = dec16_pkg::zext(16'(in_half[3:0]), 4)
                            << dec16_pkg::WLOAD_SHIFT;
      end
      dec16_pkg::MAJ_SP_WLOAD, dec16_pkg::MAJ_SP_WSTORE: begin
        short_dec.op      = (major == dec16_pkg::MAJ_SP_WLOAD) ?
                            dec16_pkg::OP_SP_WLOAD : dec16_pkg::OP_SP_WSTORE;
        short_dec.has_dst = (major == dec16_pkg::MAJ_SP_WLOAD);
        short_dec.dst     = r5a;
        short_dec.src_b   = r5a;
        short_dec.src_a   = dec16_pkg::SP_REG;
        short_dec.imm     = dec16_pkg::zext(16'(in_half[4:0]), 5)
                            << dec16_pkg::WLOAD_SHIFT;
      end
      dec16_pkg::MAJ_LOAD_IMM: begin
        short_dec.op      = dec16_pkg::OP_LOAD_IMM;
        short_dec.has_dst = 1'b1;
        short_dec.dst     = r3a;
        short_dec.imm     = dec16_pkg::zext(16'(in_half[6:0]), 7);
      end
      dec16_pkg::MAJ_BRANCH: begin
        short_dec.op  = dec16_pkg::OP_BRANCH;
        short_dec.imm = dec16_pkg::sext(16'(in_half[9:0]), 10)
                        << dec16_pkg::BRANCH_SHIFT;
      end
      dec16_pkg::MAJ_GROUP_C: begin
        if (minor5 == dec16_pkg::MIN_LINK_LONG ||
            minor5 == dec16_pkg::MIN_LINK_SHORT) begin
          short_dec.op      = (minor5 == dec16_pkg::MIN_LINK_LONG) ?
                              dec16_pkg::OP_LINK_LONG :
                              dec16_pkg::OP_LINK_SHORT;
          short_dec.src_a   = r5a;
          short_dec.has_dst = 1'b1;
          short_dec.dst     = 5'h1F;
        end else if (minor5 == dec16_pkg::MIN_BREAKS) begin
          short_dec.op  = brk_dbg ? dec16_pkg::OP_DEBUG_BREAK :
                                    dec16_pkg::OP_BREAK;
          short_dec.imm = dec16_pkg::zext(16'(in_half[9:6]), 4);
        end
      end
      default: begin
        short_dec.op = dec16_pkg::OP_RESERVED;
      end
    endcase
  end

  always_comb begin
    wide_dec         = dec16_pkg::DEC_RESET;
    wide_dec.op      = dec16_pkg::OP_WIDE;
    wide_dec.is_wide = 1'b1;
    wide_dec.raw     = {first_reg, in_half};
  end

  assign dec_sel    = (state_reg == dec16_pkg::ST_SECOND) ? wide_dec
                                                          : short_dec;
  assign out_next   = done_now ? dec_sel : out_reg;
  assign valid_next = done_now || (out_valid_reg && !out_ready && !fire);
  assign first_next = take_first ? in_half : first_reg;
  assign state_next = (take_first && !is_short) ? dec16_pkg::ST_SECOND :
                      (fire ? dec16_pkg::ST_FIRST : state_reg);

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg     <= dec16_pkg::ST_FIRST;
      first_reg     <= dec16_pkg::HALF_RESET;
      out_valid_reg <= 1'b0;
      out_reg       <= dec16_pkg::DEC_RESET;
    end else if (ce) begin
      state_reg     <= state_next;
      first_reg     <= first_next;
      out_valid_reg <= valid_next;
      out_reg       <= out_next;
    end
  end

  assign out_valid = out_valid_reg;
  assign out_dec   = out_reg;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic take16;
  assign take16 = take_first && is_short;

  chk_copy_fields: assert property (
    take16 && major == dec16_pkg::MAJ_REG_COPY |=>
      out_valid && out_dec.dst == $past(in_half[9:5]) &&
      out_dec.src_a == $past(in_half[4:0]))
    else $error("copy registers wrong");
  chk_linear_reg5: assert property (
    take16 && major == dec16_pkg::MAJ_SP_WLOAD |=>
      out_dec.dst == $past(in_half[9:5]))
    else $error("5-bit field not linear");
  chk_sp_base: assert property (
    take16 && (major == dec16_pkg::MAJ_SP_WLOAD ||
               major == dec16_pkg::MAJ_SP_WSTORE) |=>
      out_dec.src_a == dec16_pkg::SP_REG)
    else $error("sp base missing");
  chk_wload_scale: assert property (
    take16 && major == dec16_pkg::MAJ_WLOAD |=>
      out_dec.imm == {26'h0, $past(in_half[3:0]), 2'b00})
    else $error("word offset not scaled");
  chk_wload_fields: assert property (
    take16 && major == dec16_pkg::MAJ_WLOAD |=>
      out_dec.op == dec16_pkg::OP_WLOAD &&
      out_dec.dst == dec16_pkg::REG3_MAP[$past(in_half[9:7])] &&
      out_dec.src_a == dec16_pkg::REG3_MAP[$past(in_half[6:4])])
    else $error("word load fields wrong");
  chk_add_same: assert property (
    take16 && major == dec16_pkg::MAJ_GROUP_D && !minor |=>
      out_dec.dst == $past(in_half[9:5]) && out_dec.src_a == out_dec.dst)
    else $error("same register add wrong");
  chk_add_sp: assert property (
    take16 && major == dec16_pkg::MAJ_GROUP_D && minor |=>
      out_dec.dst == dec16_pkg::SP_REG &&
      out_dec.src_a == dec16_pkg::SP_REG &&
      out_dec.imm == dec16_pkg::sext(16'($past(in_half[9:1])), 9))
    else $error("sp add wrong");
  chk_add_two: assert property (
    take16 && major == dec16_pkg::MAJ_GROUP_E && !minor |=>
      out_dec.src_a == dec16_pkg::REG3_MAP[$past(in_half[6:4])] &&
      out_dec.imm == dec16_pkg::sext(16'($past(in_half[3:1])), 3))
    else $error("two register add wrong");
  chk_sp_to_reg: assert property (
    take16 && major == dec16_pkg::MAJ_GROUP_E && minor |=>
      out_dec.src_a == dec16_pkg::SP_REG &&
      out_dec.dst == dec16_pkg::REG3_MAP[$past(in_half[9:7])])
    else $error("sp to register add wrong");
  chk_no_op: assert property (
    take16 && major == dec16_pkg::MAJ_REG_COPY && in_half[9:0] == 10'h000
      |=> out_dec.op == dec16_pkg::OP_NO_OP && !out_dec.has_dst)
    else $error("no-op not recognised");
  chk_negate: assert property (
    out_valid && out_dec.op == dec16_pkg::OP_NEGATE |->
      out_dec.src_a == dec16_pkg::ZERO_REG)
    else $error("negate minuend not zero");
  chk_branch_scale: assert property (
    take16 && major == dec16_pkg::MAJ_BRANCH |=>
      out_dec.imm[0] == 1'b0 && out_dec.imm[10:1] == $past(in_half[9:0]) &&
      out_dec.imm[31] == $past(in_half[9]))
    else $error("branch offset wrong");
  chk_uadd_fields: assert property (
    take16 && major == dec16_pkg::MAJ_GROUP_A && !minor |=>
      out_dec.op == dec16_pkg::OP_UADD && out_dec.imm == 32'h0000_0000 &&
      out_dec.src_b == dec16_pkg::REG3_MAP[$past(in_half[3:1])])
    else $error("unsigned add fields wrong");
  chk_load_imm: assert property (
    take16 && major == dec16_pkg::MAJ_LOAD_IMM |=>
      out_dec.imm == {25'h0, $past(in_half[6:0])})
    else $error("load immediate wrong");
  chk_break_seen: assert property (
    take16 && major == dec16_pkg::MAJ_GROUP_C &&
      minor5 == dec16_pkg::MIN_BREAKS |=>
      out_valid && !out_dec.is_wide &&
      (out_dec.op == dec16_pkg::OP_BREAK ||
       out_dec.op == dec16_pkg::OP_DEBUG_BREAK))
    else $error("breakpoint not accepted");
  chk_link_slot: assert property (
    take16 && major == dec16_pkg::MAJ_GROUP_C &&
      minor5 == dec16_pkg::MIN_LINK_SHORT |=>
      out_dec.op == dec16_pkg::OP_LINK_SHORT)
    else $error("short slot link wrong");
  chk_size_wait: assert property (
    take_first && !is_short |=>
      state_reg == dec16_pkg::ST_SECOND && !out_valid)
    else $error("wide first half not held");
  chk_wide_pair: assert property (
    fire && state_reg == dec16_pkg::ST_SECOND |=>
      out_valid && out_dec.raw == {$past(first_reg), $past(in_half)})
    else $error("wide pairing wrong");

  cov_wide: cover property (take_first && !is_short ##1 fire);
  cov_stall: cover property (out_valid && !out_ready ##1 out_valid);
  cov_negate: cover property (out_valid &&
                              out_dec.op == dec16_pkg::OP_NEGATE);

endmodule

//--- verilog/dec16_pkg.sv
package dec16_pkg;

  localparam int HALF_W = 16;
  localparam int WORD_W = 32;
  localparam int REG_W  = 5;
  localparam int MAJ_W  = 6;

  // field positions inside a 16-bit halfword
  localparam int F_MAJ_LO  = 10;
  localparam int F_R5A_LO  = 5;
  localparam int F_R5B_LO  = 0;
  localparam int F_R3A_LO  = 7;
  localparam int F_R3B_LO  = 4;
  localparam int F_R3C_LO  = 1;
  localparam int F_MINOR   = 0;
  localparam int F_CODE_LO = 6;
  localparam int F_BRK_SEL = 5;

  localparam int WLOAD_SHIFT  = 2;
  localparam int BRANCH_SHIFT = 1;

  typedef logic [MAJ_W-1:0] major_t;
  typedef logic [REG_W-1:0] reg_idx_t;

  // major opcode assignments of the compact category
  localparam major_t MAJ_REG_COPY  = 6'h03;
  localparam major_t MAJ_GROUP_A   = 6'h01;
  localparam major_t MAJ_GROUP_C   = 6'h11;
  localparam major_t MAJ_GROUP_D   = 6'h13;
  localparam major_t MAJ_GROUP_E   = 6'h1B;
  localparam major_t MAJ_WLOAD     = 6'h1A;
  localparam major_t MAJ_WSTORE    = 6'h3A;
  localparam major_t MAJ_SP_WLOAD  = 6'h12;
  localparam major_t MAJ_SP_WSTORE = 6'h32;
  localparam major_t MAJ_LOAD_IMM  = 6'h3B;
  localparam major_t MAJ_BRANCH    = 6'h33;

  // minor codes inside the c group
  localparam logic [4:0] MIN_LINK_LONG  = 5'h0E;
  localparam logic [4:0] MIN_LINK_SHORT = 5'h0F;
  localparam logic [4:0] MIN_BREAKS     = 5'h1B;

  localparam reg_idx_t ZERO_REG = 5'h00;
  localparam reg_idx_t SP_REG   = 5'h1D;

  // reduced register set seen through 3-bit fields
  localparam reg_idx_t REG3_MAP [8] = '{5'h00, 5'h01, 5'h02, 5'h03,
                                         5'h04, 5'h05, 5'h06, 5'h07};

  typedef enum logic [4:0] {
    OP_NONE, OP_WIDE, OP_RESERVED, OP_REG_COPY, OP_NO_OP,
    OP_ADD_SAME, OP_ADD_SP, OP_ADD_TWO, OP_ADD_SP_REG,
    OP_UADD, OP_USUB, OP_NEGATE, OP_WLOAD, OP_WSTORE,
    OP_SP_WLOAD, OP_SP_WSTORE, OP_LOAD_IMM, OP_BRANCH,
    OP_LINK_LONG, OP_LINK_SHORT, OP_BREAK, OP_DEBUG_BREAK
  } op_t;

  typedef enum logic {ST_FIRST, ST_SECOND} asm_state_t;

  typedef struct packed {
    op_t                 op;
    logic                is_wide;
    logic                has_dst;
    reg_idx_t            dst;
    reg_idx_t            src_a;
    reg_idx_t            src_b;
    logic [WORD_W-1:0]   imm;
    logic [WORD_W-1:0]   raw;
  } dec_out_t;

  localparam dec_out_t DEC_RESET = '{op: OP_NONE, default: '0};
  localparam logic [HALF_W-1:0] HALF_RESET = 16'h0000;

  function automatic logic [WORD_W-1:0] sext(input logic [HALF_W-1:0] v,
                                              input int unsigned w);
    logic [WORD_W-1:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < WORD_W; i++) begin
      r[i] = (i < w) ? v[i] : v[w-1];
    end
    return r;
  endfunction

  function automatic logic [WORD_W-1:0] zext(input logic [HALF_W-1:0] v,
                                              input int unsigned w);
    logic [WORD_W-1:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < WORD_W; i++) begin
      r[i] = (i < w) ? v[i] : 1'b0;
    end
    return r;
  endfunction

endpackage

//--- verilog/size_classifier.sv
module size_classifier (
  input  wire dec16_pkg::major_t major,
  output logic                   is_short
);
  // the major opcode alone tells halfword from word instructions
  assign is_short = (major == dec16_pkg::MAJ_REG_COPY)  ||
                    (major == dec16_pkg::MAJ_GROUP_A)   ||
                    (major == dec16_pkg::MAJ_GROUP_C)   ||
                    (major == dec16_pkg::MAJ_GROUP_D)   ||
                    (major == dec16_pkg::MAJ_GROUP_E)   ||
                    (major == dec16_pkg::MAJ_WLOAD)     ||
                    (major == dec16_pkg::MAJ_WSTORE)    ||
                    (major == dec16_pkg::MAJ_SP_WLOAD)  ||
                    (major == dec16_pkg::MAJ_SP_WSTORE) ||
                    (major == dec16_pkg::MAJ_LOAD_IMM)  ||
                    (major == dec16_pkg::MAJ_BRANCH);
endmodule

//--- verilog/reg3_map.sv
module reg3_map (
  input  wire logic [2:0]          code,
  output dec16_pkg::reg_idx_t      reg_idx
);
  assign reg_idx = dec16_pkg::REG3_MAP[code];
endmodule

//--- dv/fetch_model.sv
// fetch side offers halfwords in order, consumer side stalls at random
module fetch_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        in_ready,
  input  wire logic        out_valid,
  output logic             in_valid,
  output logic [15:0]      in_half,
  output logic             out_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] feed [$];
  int          seed = 68323;
  bit          taken;

  initial begin
    in_valid  = 1'b0;
    in_half   = 16'h0000;
    out_ready = 1'b0;
  end

  // an offer is held until taken; idle data keeps changing
  always @(posedge clk) begin
    taken = in_valid && in_ready;
    #1;
    if (taken) begin
      void'(feed.pop_front());
    end
    if (taken || !in_valid) begin
      if (!rst && feed.size() > 0 && ($random(seed) & 3) != 0) begin
        in_valid = 1'b1;
        in_half  = feed[0];
      end else begin
        in_valid = 1'b0;
        in_half  = ~in_half;
      end
    end
    out_ready = ($random(seed) & 3) != 0;
  end
endmodule

//--- dv/compact_instr_field_decoder_bench.sv
module compact_instr_field_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                clk;
  logic                rst;
  logic                ce;
  logic                in_valid;
  logic                in_ready;
  logic                out_valid;
  logic                out_ready;
  logic [15:0]         in_half;
  dec16_pkg::dec_out_t out_dec;
  dec16_pkg::dec_out_t exp_q [$];
  dec16_pkg::dec_out_t e_now;
  logic [4:0]          mask_q [$];
  logic [4:0]          m_now;
  int                  num_errors = 0;
  int                  checked = 0;
  int                  seed = 68323;
  int                  cycles = 0;
  bit                  running = 1'b0;
  logic [15:0]         corners [26] = '{16'h0C00, 16'h0C21, 16'h0FFF,
    16'h078B, 16'h0413, 16'h0412, 16'h4FFE, 16'h4FFF, 16'h4C01,
    16'h6FFE, 16'h6FFF, 16'hCE00, 16'hCDFF, 16'hEC7F, 16'h680F,
    16'hE80F, 16'h481F, 16'hC81F, 16'h47EE, 16'h47EF, 16'h47DB,
    16'h47FB, 16'h4400, 16'h0000, 16'hFFFF, 16'h0C00};
  logic [5:0]          majors [11] = '{6'h03, 6'h13, 6'h1B, 6'h01,
    6'h1A, 6'h3A, 6'h12, 6'h32, 6'h3B, 6'h33, 6'h11};

  compact_instr_field_decoder DUT (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (in_valid),
    .in_half   (in_half),
    .in_ready  (in_ready),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_dec   (out_dec)
  );

  fetch_model partner (
    .clk       (clk),
    .rst       (rst),
    .in_ready  (in_ready),
    .out_valid (out_valid),
    .in_valid  (in_valid),
    .in_half   (in_half),
    .out_ready (out_ready)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report();
    if (num_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // mask bits: dst, src_a, src_b, imm, raw
  function automatic dec16_pkg::dec_out_t want(input logic [15:0] h,
      input logic [15:0] h2, output logic [4:0] m);
    dec16_pkg::dec_out_t e;
    dec16_pkg::reg_idx_t a3, b3, a5, b5, sp;
    e  = dec16_pkg::DEC_RESET;
    a3 = {2'b00, h[9:7]};
    b3 = {2'b00, h[6:4]};
    a5 = h[9:5];
    b5 = h[4:0];
    sp = 5'h1D;
    m  = 5'h03;
    case (h[15:10])
      6'h03: begin
        e.op = (a5 == 0 && b5 == 0) ? dec16_pkg::OP_NO_OP
                                    : dec16_pkg::OP_REG_COPY;
        e.dst = a5;
        e.src_a = b5;
      end
      6'h13: begin
        m = 5'h0B;
        e.op = h[0] ? dec16_pkg::OP_ADD_SP : dec16_pkg::OP_ADD_SAME;
        e.dst = h[0] ? sp : a5;
        e.src_a = e.dst;
        e.imm = h[0] ? 32'($signed(h[9:1])) : 32'($signed(h[4:1]));
      end
      6'h1B: begin
        m = 5'h0B;
        e.op = h[0] ? dec16_pkg::OP_ADD_SP_REG : dec16_pkg::OP_ADD_TWO;
        e.dst = a3;
        e.src_a = h[0] ? sp : b3;
        e.imm = h[0] ? {26'h0, h[6:1]} : 32'($signed(h[3:1]));
      end
      6'h01: begin
        m = 5'h07;
        e.op = !h[0] ? dec16_pkg::OP_UADD :
               (b3 == 0) ? dec16_pkg::OP_NEGATE : dec16_pkg::OP_USUB;
        e.dst = a3;
        e.src_a = b3;
        e.src_b = {2'b00, h[3:1]};
      end
      6'h1A, 6'h3A, 6'h12, 6'h32: begin
        m = h[15] ? 5'h0E : 5'h0B;
        e.op = h[15] ? (h[13] ? dec16_pkg::OP_WSTORE
                              : dec16_pkg::OP_SP_WSTORE)
                     : (h[13] ? dec16_pkg::OP_WLOAD
                              : dec16_pkg::OP_SP_WLOAD);
        e.dst = h[15] ? 5'h00 : (h[13] ? a3 : a5);
        e.src_b = h[15] ? (h[13] ? a3 : a5) : 5'h00;
        e.src_a = h[13] ? b3 : sp;
        e.imm = h[13] ? {26'h0, h[3:0], 2'b00} : {25'h0, h[4:0], 2'b00};
      end
      6'h3B: begin
        m = 5'h09;
        e.op = dec16_pkg::OP_LOAD_IMM;
        e.dst = a3;
        e.imm = {25'h0, h[6:0]};
      end
      6'h33: begin
        m = 5'h08;
        e.op = dec16_pkg::OP_BRANCH;
        e.imm = 32'($signed(h[9:0])) << 1;
      end
      6'h11: begin
        e.dst = 5'h1F;
        e.src_a = a5;
        e.op = (b5 == 5'h0E) ? dec16_pkg::OP_LINK_LONG :
               (b5 == 5'h0F) ? dec16_pkg::OP_LINK_SHORT :
               dec16_pkg::OP_RESERVED;
        if (b5 == 5'h1B) begin
          m = 5'h08;
          e.op = h[5] ? dec16_pkg::OP_DEBUG_BREAK : dec16_pkg::OP_BREAK;
          e.imm = {28'h0, h[9:6]};
        end else if (e.op == dec16_pkg::OP_RESERVED) begin
          m = 5'h00;
        end
      end
      default: begin
        m = 5'h10;
        e.op = dec16_pkg::OP_WIDE;
        e.is_wide = 1'b1;
        e.raw = {h, h2};
      end
    endcase
    // a written register exists exactly where dst is meaningful, no-op aside
    e.has_dst = m[0] && (e.op != dec16_pkg::OP_NO_OP);
    return e;
  endfunction

  task automatic send(input logic [15:0] h, input logic [15:0] h2);
    logic [4:0]          m;
    dec16_pkg::dec_out_t e;
    e = want(h, h2, m);
    exp_q.push_back(e);
    mask_q.push_back(m);
    partner.feed.push_back(h);
    if (e.is_wide) begin
      partner.feed.push_back(h2);
    end
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      final_report();
    end
    if (running && out_valid && out_ready && ce) begin
      if (exp_q.size() == 0) begin
        check(32'h1, 32'h0, "unexpected result");
      end else begin
        e_now = exp_q.pop_front();
        m_now = mask_q.pop_front();
        check(32'(out_dec.op), 32'(e_now.op), "op");
        check(32'(out_dec.is_wide), 32'(e_now.is_wide), "size");
        check(32'(out_dec.has_dst), 32'(e_now.has_dst), "has_dst");
        if (m_now[0]) check(32'(out_dec.dst), 32'(e_now.dst), "dst");
        if (m_now[1]) check(32'(out_dec.src_a), 32'(e_now.src_a), "src_a");
        if (m_now[2]) check(32'(out_dec.src_b), 32'(e_now.src_b), "src_b");
        if (m_now[3]) check(out_dec.imm, e_now.imm, "imm");
        if (m_now[4]) check(out_dec.raw, e_now.raw, "raw");
      end
    end
  end

  // clock enable dropped now and then to freeze the pipe
  always @(posedge clk) begin
    #1;
    if (running) begin
      ce = ($random(seed) & 7) != 0;
    end
  end

  initial begin
    logic [15:0] h;
    rst = 1'b1;
    ce  = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    check(32'(out_valid), 32'h0, "valid after reset");
    running = 1'b1;
    foreach (corners[i]) begin
      send(corners[i], 16'($random(seed)));
    end
    repeat (400) begin
      h = 16'($random(seed));
      if (($random(seed) & 7) != 0) begin
        h[15:10] = majors[($random(seed) & 32'h7FFF) % 11];
      end
      send(h, 16'($random(seed)));
    end
    for (int i = 0; i < 20000 && exp_q.size() > 0; i++) begin
      @(posedge clk);
    end
    check(32'(exp_q.size()), 32'h0, "results missing");
    final_report();
  end
endmodule
